// file: lpmc_pkg.sv
// constants, types and register map of the low power mode controller
package lpmc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned RST_HOLD_NS  = 100;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned EXT_LINES = 16;
    localparam int unsigned BKP_REGS  = 10;
    localparam int unsigned BKP_W     = 16;
    localparam int unsigned WAKE_W    = 19;
    localparam int unsigned IRQ_W     = 4;
    localparam int unsigned CTRL_W    = 8;
    localparam int unsigned SYNC_W    = 23;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_WAKE_EN  = 8'h10;
    localparam logic [7:0] OFS_BKP_BASE = 8'h40;
    // ------------------------------------------------------------
    // bit positions
    // ------------------------------------------------------------
    localparam int unsigned SI_SUP  = 16;
    localparam int unsigned SI_STM  = 17;
    localparam int unsigned SI_RTC  = 18;
    localparam int unsigned SI_USB  = 19;
    localparam int unsigned SI_WKP  = 20;
    localparam int unsigned SI_RESET_PIN_N = 21;
    localparam int unsigned SI_INDEPENDENT_WATCHDOG = 22;
    localparam int unsigned IRQ_STM_FALL = 0;
    localparam int unsigned IRQ_STM_RISE = 1;
    localparam int unsigned IRQ_STOP_WK  = 2;
    localparam int unsigned IRQ_STBY_WK  = 3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [IRQ_W-1:0]  MASK_RST = 4'h0;
    localparam logic [IRQ_W-1:0]  STBY_KEEP = 4'h8;
    localparam logic [WAKE_W-1:0] WAKE_RST = 19'h0_0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LP_SLEEP, LP_STOP, LP_STANDBY, LP_RSVD} lpmc_lp_t;
    typedef enum logic [1:0] {CLK_IFO, CLK_EFO, CLK_PLL, CLK_RSVD} lpmc_clk_t;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STOP, ST_STANDBY} lpmc_state_t;
    typedef struct packed {
        lpmc_clk_t  sysclk;
        logic       stop_lp;
        lpmc_lp_t   lp_mode;
        logic [1:0] stm_edge;
        logic       stm_en;
    } lpmc_ctrl_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic ifo_en;
        logic efo_en;
        logic reg_en;
        logic reg_lp;
    } lpmc_pwr_t;
    localparam lpmc_pwr_t PWR_RUN = 7'h7E;
    localparam lpmc_pwr_t PWR_OFF = 7'h00;
endpackage

// file: lpmc_top.sv
// low power mode controller: supply reset, threshold monitor, sleep/stop/standby
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - hold whole chip in reset while supply reset detector reports low supply
// - threshold monitor interrupts on falling, rising or both crossings
// - threshold monitor stays inactive until software enables it
// - regulator modes: main in run, main or low power in stop, off in standby
// - regulator enabled after any reset, disabled only in standby
// - sleep gates only cpu clock, any interrupt or event resumes it
// - stop gates core clocks, pll and both fast oscillators, keeps state
// - stop regulator mode normal or low power, chosen before entry
// - stop exits on any enabled event line: 16 pins, monitor, alarm, usb
// - standby turns off regulator, pll and fast oscillators
// - standby exits on reset pin, watchdog reset, wakeup rise, alarm
// - low speed clocks for rtc and watchdog keep running in all modes
// - ten 16-bit backup registers, fed from battery when supply absent
// - wake from stop or standby runs on internal fast oscillator
// - wake from sleep keeps the clock source selected before sleep
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter logic [7:0] RST_HOLD = 8'(RST_HOLD_CYC)
)(
    input  wire logic                 clock_i,                    // system clock
    input  wire logic                 sys_rst_i,                  // async reset
    input  wire logic                 psel_i,                     // apb select
    input  wire logic                 penable_i,                  // apb enable
    input  wire logic                 pwrite_i,                   // apb write
    input  wire logic [7:0]           paddr_i,                    // apb address
    input  wire logic [31:0]          pwdata_i,                   // apb write data
    output logic [31:0]               prdata_o,                   // apb read data
    output logic                      pready_o,                   // apb ready
    output logic                      pslverr_o,                  // apb error
    input  wire logic                 supply_reset_detector_i,    // high: supply low
    input  wire logic                 supply_threshold_monitor_i, // high: below
    input  wire logic [EXT_LINES-1:0] external_event_lines_i,     // event pins
    input  wire logic                 rtc_alarm_i,                // rtc alarm
    input  wire logic                 usb_wakeup_i,               // usb wakeup
    input  wire logic                 wakeup_pin_i,               // wakeup pin
    input  wire logic                 reset_pin_n_i,              // reset pin
    input  wire logic                 independent_watchdog_i,     // wdg reset
    input  wire logic                 core_idle_req_i,            // core idle
    input  wire logic                 core_irq_pending_i,         // core irq/event
    output logic                      chip_rst_o,                 // chip reset
    output logic                      core_rst_o,                 // core reset
    output logic                      cpu_clk_en_o,               // cpu clock
    output logic                      core_clk_en_o,              // core clocks
    output logic                      pll_en_o,                   // pll enable
    output logic                      ifo_en_o,                   // int osc
    output logic                      efo_en_o,                   // ext osc
    output logic                      regulator_en_o,             // regulator on
    output logic                      regulator_lp_o,             // low power reg
    output logic [1:0]                sysclk_sel_o,               // clock source
    output logic                      battery_sel_o,              // backup on batt
    output logic                      lowspeed_run_o,             // rtc/wdg clocks
    output logic                      irq_o                       // interrupt
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync_in_w;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] prev_q;
    logic [SYNC_W-1:0] rise_w;
    logic [SYNC_W-1:0] fall_w;

    // reset pin inverted before sync so every flop resets to zero
    assign sync_in_w = {independent_watchdog_i, ~reset_pin_n_i, wakeup_pin_i,
                        usb_wakeup_i, rtc_alarm_i, supply_threshold_monitor_i,
                        supply_reset_detector_i, external_event_lines_i};

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q   <= '0;
            s2_q   <= '0;
            prev_q <= '0;
        end else begin
            s1_q   <= sync_in_w;
            s2_q   <= s1_q;
            prev_q <= s2_q;
        end
    end

    assign rise_w = s2_q & ~prev_q;
    assign fall_w = ~s2_q & prev_q;

    // ------------------------------------------------------------
    // state and events
    // ------------------------------------------------------------
    lpmc_ctrl_t        ctrl_q;
    lpmc_ctrl_t        ctrl_d;
    lpmc_state_t       state_q;
    lpmc_state_t       state_d;
    lpmc_state_t       state_n_w;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_stat_d;
    logic [IRQ_W-1:0]  mask_q;
    logic [WAKE_W-1:0] wake_en_q;
    logic [WAKE_W-1:0] line_ev_w;
    logic [7:0]        rst_cnt_q;
    logic [7:0]        rst_cnt_d;
    logic              chip_rst_q;
    logic              core_rst_q;
    logic              core_clr_w;
    logic              supply_low_w;
    logic              stm_fall_w;
    logic              stm_rise_w;
    logic              wake_ev_w;
    logic              stby_wake_w;
    logic              stop_exit_w;
    logic              stby_exit_w;
    logic              core_rst_req_w;

    assign supply_low_w = s2_q[SI_SUP];
    assign core_clr_w   = core_rst_q | chip_rst_q;
    // monitor high means supply below threshold: its rise is a falling supply
    assign stm_fall_w = ctrl_q.stm_en & ctrl_q.stm_edge[0] & rise_w[SI_STM];
    assign stm_rise_w = ctrl_q.stm_en & ctrl_q.stm_edge[1] & fall_w[SI_STM];
    assign line_ev_w  = {rise_w[SI_USB], rise_w[SI_RTC], stm_fall_w | stm_rise_w,
                         rise_w[EXT_LINES-1:0]};
    assign wake_ev_w  = |(line_ev_w & wake_en_q);
    assign stby_wake_w = s2_q[SI_RESET_PIN_N] | s2_q[SI_INDEPENDENT_WATCHDOG]
                       | rise_w[SI_WKP] | rise_w[SI_RTC];
    assign stop_exit_w = (state_q == ST_STOP) & wake_ev_w;
    assign stby_exit_w = (state_q == ST_STANDBY) & stby_wake_w;
    assign core_rst_req_w = s2_q[SI_RESET_PIN_N] | s2_q[SI_INDEPENDENT_WATCHDOG] | stby_exit_w;
    assign state_n_w = chip_rst_q ? ST_RUN : state_d;

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (core_idle_req_i && !core_clr_w) begin
                    unique case (ctrl_q.lp_mode)
                        LP_STOP:    state_d = ST_STOP;
                        LP_STANDBY: state_d = ST_STANDBY;
                        default:    state_d = ST_SLEEP;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (core_irq_pending_i || wake_ev_w) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (wake_ev_w) begin
                    state_d = ST_RUN;
                end
            end
            ST_STANDBY: begin
                if (stby_wake_w) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // power and clock enables per mode
    function automatic lpmc_pwr_t pwr_of(input lpmc_state_t st, input logic lp);
        lpmc_pwr_t p;
        p = PWR_RUN;
        unique case (st)
            ST_RUN:     p = PWR_RUN;
            ST_SLEEP:   p.cpu_clk_en = 1'b0;
            ST_STOP: begin
                p = PWR_OFF;
                p.reg_en = 1'b1;
                p.reg_lp = lp;
            end
            ST_STANDBY: p = PWR_OFF;
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [BKP_W-1:0] bkp_q [BKP_REGS];
    logic [31:0]      rdata_w;
    logic [3:0]       bkp_idx_w;
    logic             acc_w;
    logic             wr_w;
    logic             hit_ctrl_w;
    logic             hit_stat_w;
    logic             hit_irq_w;
    logic             hit_mask_w;
    logic             hit_wake_w;
    logic             hit_bkp_w;
    logic             mapped_w;
    logic             pready_d;

    // one wait state: data and ready both leave flops
    assign pready_d   = psel_i & penable_i & ~pready_o;
    assign acc_w      = psel_i & penable_i & pready_o;
    assign wr_w       = acc_w & pwrite_i;
    assign bkp_idx_w  = paddr_i[5:2];
    assign hit_ctrl_w = (paddr_i == OFS_CTRL);
    assign hit_stat_w = (paddr_i == OFS_STATUS);
    assign hit_irq_w  = (paddr_i == OFS_IRQ_STAT);
    assign hit_mask_w = (paddr_i == OFS_IRQ_MASK);
    assign hit_wake_w = (paddr_i == OFS_WAKE_EN);
    assign hit_bkp_w  = (paddr_i[7:6] == OFS_BKP_BASE[7:6]) && (paddr_i[1:0] == 2'h0)
                      && (32'(bkp_idx_w) < BKP_REGS);
    assign mapped_w   = hit_ctrl_w | hit_stat_w | hit_irq_w | hit_mask_w
                      | hit_wake_w | hit_bkp_w;
    assign rdata_w = hit_ctrl_w ? 32'(ctrl_q)
                   : hit_stat_w ? 32'({state_q, s2_q[SI_STM], supply_low_w})
                   : hit_irq_w  ? 32'(irq_stat_q)
                   : hit_mask_w ? 32'(mask_q)
                   : hit_wake_w ? 32'(wake_en_q)
                   : hit_bkp_w  ? 32'(bkp_q[bkp_idx_w])
                   : 32'h0000_0000;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= pready_d;
            pslverr_o <= pready_d & ~mapped_w;
            prdata_o  <= pready_d ? rdata_w : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // core domain registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_w && hit_ctrl_w) begin
            ctrl_d = lpmc_ctrl_t'(pwdata_i[CTRL_W-1:0]);
        end
        if (stop_exit_w) begin
            ctrl_d.sysclk = CLK_IFO;
        end
    end

    // set wins over a clear written in the same cycle
    assign irq_stat_d = (irq_stat_q & ~((wr_w && hit_irq_w) ? pwdata_i[IRQ_W-1:0] : 4'h0))
                      | {stby_exit_w, stop_exit_w, stm_rise_w, stm_fall_w};

    // cleared by core reset; the standby wake flag lives in standby circuitry
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q     <= CTRL_RST;
            mask_q     <= MASK_RST;
            wake_en_q  <= WAKE_RST;
            irq_stat_q <= 4'h0;
        end else if (core_clr_w) begin
            ctrl_q     <= CTRL_RST;
            mask_q     <= MASK_RST;
            wake_en_q  <= WAKE_RST;
            irq_stat_q <= irq_stat_d & STBY_KEEP;
        end else begin
            ctrl_q     <= ctrl_d;
            mask_q     <= (wr_w && hit_mask_w) ? pwdata_i[IRQ_W-1:0] : mask_q;
            wake_en_q  <= (wr_w && hit_wake_w) ? pwdata_i[WAKE_W-1:0] : wake_en_q;
            irq_stat_q <= irq_stat_d;
        end
    end

    // backup registers: reset only at power-on, survive core reset and standby
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < BKP_REGS; i++) begin
                bkp_q[i] <= 16'h0000;
            end
        end else if (wr_w && hit_bkp_w && !chip_rst_q) begin
            bkp_q[bkp_idx_w] <= pwdata_i[BKP_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // resets and outputs
    // ------------------------------------------------------------
    assign rst_cnt_d = core_rst_req_w ? RST_HOLD
                     : (rst_cnt_q != 8'h00) ? rst_cnt_q - 8'h01 : 8'h00;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q        <= ST_RUN;
            rst_cnt_q      <= 8'h00;
            chip_rst_q     <= 1'b1;
            core_rst_q     <= 1'b0;
            {cpu_clk_en_o, core_clk_en_o, pll_en_o, ifo_en_o,
             efo_en_o, regulator_en_o, regulator_lp_o} <= PWR_RUN;
            sysclk_sel_o   <= CLK_IFO;
            battery_sel_o  <= 1'b0;
            lowspeed_run_o <= 1'b1;
            irq_o          <= 1'b0;
        end else begin
            state_q        <= state_n_w;
            rst_cnt_q      <= rst_cnt_d;
            chip_rst_q     <= supply_low_w;
            core_rst_q     <= (rst_cnt_d != 8'h00);
            {cpu_clk_en_o, core_clk_en_o, pll_en_o, ifo_en_o,
             efo_en_o, regulator_en_o, regulator_lp_o} <= pwr_of(state_n_w, ctrl_q.stop_lp);
            sysclk_sel_o   <= core_clr_w ? CLK_IFO : ctrl_d.sysclk;
            battery_sel_o  <= supply_low_w;
            lowspeed_run_o <= 1'b1;
            irq_o          <= |(irq_stat_q & mask_q);
        end
    end

    assign chip_rst_o = chip_rst_q;
    assign core_rst_o = core_rst_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_chip_rst_hold: assert property (supply_low_w |=> chip_rst_o)
        else $error("chip reset not held on low supply");
    a_stm_fall_flag: assert property ((stm_fall_w && !core_clr_w)
        |=> irq_stat_q[IRQ_STM_FALL])
        else $error("falling crossing flag missing");
    a_stm_off_quiet: assert property (!ctrl_q.stm_en
        |=> !$rose(irq_stat_q[IRQ_STM_FALL]) && !$rose(irq_stat_q[IRQ_STM_RISE]))
        else $error("monitor flag set while disabled");
    a_sleep_cpu_gate: assert property ((state_q == ST_SLEEP)
        |-> !cpu_clk_en_o && core_clk_en_o && regulator_en_o)
        else $error("sleep clock gating wrong");
    a_stop_clk_off: assert property ((state_q == ST_STOP)
        |-> !core_clk_en_o && !pll_en_o && !ifo_en_o && !efo_en_o)
        else $error("stop left a clock running");
    a_stop_reg_mode: assert property ((state_q == ST_STOP)
        |-> regulator_en_o && (regulator_lp_o == ctrl_q.stop_lp))
        else $error("stop regulator mode wrong");
    a_stop_line_wake: assert property ((state_q == ST_STOP && wake_ev_w)
        |=> state_q == ST_RUN && sysclk_sel_o == CLK_IFO)
        else $error("stop exit wrong");
    a_stby_power_off: assert property ((state_q == ST_STANDBY)
        |-> !regulator_en_o && !pll_en_o && !ifo_en_o && !efo_en_o)
        else $error("standby left power on");
    a_stby_exit_rst: assert property (stby_exit_w
        |=> core_rst_o && state_q == ST_RUN ##1 core_rst_o)
        else $error("standby exit without core reset");
    a_reg_on_run: assert property ((state_q != ST_STANDBY) |-> regulator_en_o)
        else $error("regulator off outside standby");
    a_sleep_clk_keep: assert property ((state_q == ST_SLEEP && state_d == ST_RUN
        && !core_clr_w) |=> sysclk_sel_o == $past(ctrl_q.sysclk))
        else $error("sleep wake changed clock source");
    a_lowspeed_on: assert property (lowspeed_run_o)
        else $error("low speed clocks stopped");
endmodule

// file: lpmc_core_model.sv
// processor core model: idle requests and pending interrupts
`timescale 1ns/1ps
module lpmc_core_model (
    input  wire logic clock_i,       // system clock
    input  wire logic sys_rst_i,     // async reset
    input  wire logic core_rst_i,    // core held in reset
    input  wire logic idle_cmd_i,    // bench asks for idle
    input  wire logic irq_cmd_i,     // bench raises interrupt
    output logic      idle_req_o,    // one-cycle idle request
    output logic      irq_pending_o  // pending interrupt level
);
    // ------------------------------------------------------------
    // core behaviour
    // ------------------------------------------------------------
    // the bench writes the mode bits before idle_cmd_i; a core in reset stays quiet
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_req_o    <= 1'b0;
            irq_pending_o <= 1'b0;
        end else begin
            idle_req_o    <= idle_cmd_i & ~core_rst_i & ~idle_req_o;
            irq_pending_o <= irq_cmd_i & ~core_rst_i;
        end
    end
endmodule

// file: test_low_power_mode_controller.sv
// self-checking bench for the low power mode controller
`timescale 1ns/1ps
module test_low_power_mode_controller import lpmc_pkg::*;;
    logic        clock_i, sys_rst_i, psel, penable, pwrite, supply_rst, stm, wkp;
    logic        idle_cmd, irq_cmd, idle_req, irq_pend, pready, pslverr, chip_rst, core_rst;
    logic        cpu_en, core_en, pll_en, ifo_en, efo_en, reg_en, reg_lp, batt_sel, ls_run, irq;
    logic [1:0]  sysclk;
    logic [7:0]  paddr;
    logic [15:0] ext;
    logic [31:0] pwdata, prdata;
    int          fail_count = 0;
    int          n_tests = 0;
    // ------------------------------------------------------------
    // design and core model
    // ------------------------------------------------------------
    lpmc_top #(.RST_HOLD(8'h02)) u_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .supply_reset_detector_i(supply_rst),
        .supply_threshold_monitor_i(stm), .external_event_lines_i(ext), .rtc_alarm_i(1'b0),
        .usb_wakeup_i(1'b0), .wakeup_pin_i(wkp), .reset_pin_n_i(1'b1),
        .independent_watchdog_i(1'b0), .core_idle_req_i(idle_req),
        .core_irq_pending_i(irq_pend), .chip_rst_o(chip_rst), .core_rst_o(core_rst),
        .cpu_clk_en_o(cpu_en), .core_clk_en_o(core_en), .pll_en_o(pll_en), .ifo_en_o(ifo_en),
        .efo_en_o(efo_en), .regulator_en_o(reg_en), .regulator_lp_o(reg_lp),
        .sysclk_sel_o(sysclk), .battery_sel_o(batt_sel), .lowspeed_run_o(ls_run), .irq_o(irq)
    );
    lpmc_core_model u_core (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .core_rst_i(core_rst),
        .idle_cmd_i(idle_cmd), .irq_cmd_i(irq_cmd), .idle_req_o(idle_req),
        .irq_pending_o(irq_pend)
    );
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // request held until pready is seen high; a spare edge keeps drivers apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(w, q, exp);
    endtask
    task automatic idle;
        idle_cmd <= 1'b1;
        tick(1);
        idle_cmd <= 1'b0;
        tick(4);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        int          n;
        {psel, penable, pwrite, stm, wkp, idle_cmd, irq_cmd, paddr, pwdata, ext} = '0;
        sys_rst_i  = 1'b1;
        supply_rst = 1'b1;
        tick(12);
        sys_rst_i <= 1'b0;
        tick(4);
        chk("chip reset", {chip_rst, batt_sel}, 2'h3);
        supply_rst <= 1'b0;
        tick(8);
        chk("run outputs", {chip_rst, cpu_en, core_en, reg_en, reg_lp, ls_run, sysclk}, 8'h74);
        $display("test reset done");
        wr(OFS_CTRL, 32'h0000_0080);
        rd("ctrl", OFS_CTRL, 32'h0000_0080);
        apb(1'b0, 8'h20, 32'h0000_0000, q, e);
        chk("unmapped error", 32'(e), 32'h0000_0001);
        chk("unmapped data", q, 32'h0000_0000);
        wr(8'h64, 32'hFFFF_A5C3);
        rd("backup", 8'h64, 32'h0000_A5C3);
        wr(OFS_CTRL, 32'h0000_0006);
        stm <= 1'b1;
        tick(6);
        rd("monitor off", OFS_IRQ_STAT, 32'h0000_0000);
        stm <= 1'b0;
        tick(6);
        wr(OFS_CTRL, 32'h0000_0007);
        stm <= 1'b1;
        tick(6);
        stm <= 1'b0;
        tick(6);
        chk("masked irq", irq, 1'h0);
        rd("crossings", OFS_IRQ_STAT, 32'h0000_0003);
        wr(OFS_IRQ_MASK, 32'h0000_000F);
        tick(2);
        chk("irq raised", irq, 1'h1);
        wr(OFS_IRQ_STAT, 32'h0000_0003);
        tick(2);
        chk("irq cleared", irq, 1'h0);
        $display("test monitor done");
        wr(OFS_CTRL, 32'h0000_0080);
        idle();
        chk("sleep", {cpu_en, core_en, pll_en}, 3'h3);
        irq_cmd <= 1'b1;
        tick(4);
        chk("sleep wake", {cpu_en, sysclk}, 3'h6);
        irq_cmd <= 1'b0;
        wr(OFS_WAKE_EN, 32'h0000_0008);
        // both stop regulator choices; line 2 is not enabled and must not wake
        for (int lp = 0; lp < 2; lp++) begin
            wr(OFS_CTRL, 32'h0000_00A8 & ~32'((1 - lp) << 5));
            idle();
            chk("stop", {cpu_en, core_en, pll_en, ifo_en, efo_en, reg_en, reg_lp}, 7'h02 | 7'(lp));
            ext[2] <= 1'b1;
            tick(8);
            chk("other line", core_en, 1'h0);
            ext[3] <= 1'b1;
            tick(8);
            chk("stop wake", {core_en, ifo_en, sysclk}, 4'hC);
            rd("stop flag", OFS_IRQ_STAT, 32'h0000_0004);
            wr(OFS_IRQ_STAT, 32'h0000_0004);
            ext <= '0;
            tick(4);
        end
        wr(OFS_CTRL, 32'h0000_0010);
        idle();
        chk("standby", {reg_en, pll_en, ifo_en, efo_en, ls_run}, 5'h01);
        wkp <= 1'b1;
        n = 0;
        while (core_rst !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        chk("exit reset", core_rst, 1'h1);
        tick(12);
        chk("exit run", {core_rst, reg_en, core_en, sysclk}, 5'h0C);
        rd("standby flag", OFS_IRQ_STAT, 32'h0000_0008);
        rd("ctrl cleared", OFS_CTRL, 32'h0000_0000);
        rd("backup kept", 8'h64, 32'h0000_A5C3);
        wkp <= 1'b0;
        $display("test low power modes done");
        results();
    end
endmodule
